// ---- design/fcb_host.sv ----
`timescale 1ns/100ps
`default_nettype none
// host end: turns one request into a sequence of flash bus cycles
module fcb_host
   import fcb_pkg::*;
#(
   parameter int SETUP_CYC  = FCB_SETUP_CYC,
   parameter int STROBE_CYC = FCB_STROBE_CYC,
   parameter int READ_CYC   = FCB_READ_CYC
) (
   input  wire logic      ref_clk_in,
   input  wire logic      sys_rst_in,
   input  wire fcb_req_t  req_in,
   input  wire logic      req_valid_in,
   output logic           req_ready_out,
   output logic [7:0]     rd_data_out,
   output logic           rd_valid_out,
   output logic           busy_out,
   output fcb_pins_t      pins_out,
   input  wire logic [7:0] dq_in,
   input  wire logic      supply_high_in,
   output logic           id_high_voltage_out
);
   initial begin
      if (SETUP_CYC < 1 || STROBE_CYC < 1 || READ_CYC < 1 || READ_CYC > 255) begin
         $error("fcb_host: phase counts out of range");
      end
   end

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SETUP,
      ST_STROBE,
      ST_HOLD,
      ST_READ,
      ST_GAP
   } fcb_st_t;

   fcb_st_t     st_q, st_d;
   fcb_req_t    req_q, req_d;
   logic [7:0]  cnt_q, cnt_d;
   logic [1:0]  seq_q, seq_d;     // bus cycles left in this request
   logic        rd_q, rd_d;       // current cycle is a read
   fcb_pins_t   pin_q, pin_d;
   logic [7:0]  rdat_q, rdat_d;
   logic        rval_q, rval_d;
   logic        idv_q, idv_d;

   assign req_ready_out       = (st_q == ST_IDLE);
   assign busy_out            = (st_q != ST_IDLE);
   assign rd_data_out         = rdat_q;
   assign rd_valid_out        = rval_q;
   assign pins_out            = pin_q;
   assign id_high_voltage_out = idv_q;

   // number of bus cycles for each request
   function automatic logic [1:0] op_cycles(input fcb_op_t op);
      case (op)
         FCB_OP_READ,
         FCB_OP_WRITE,
         FCB_OP_ARRAY:    op_cycles = 2'd1;
         FCB_OP_SIG:      op_cycles = 2'd1;
         default:         op_cycles = 2'd2;
      endcase
   endfunction : op_cycles

   // byte written on bus cycle n of a request
   function automatic logic [7:0] op_byte(input fcb_req_t r, input logic first);
      case (r.op)
         FCB_OP_ARRAY:    op_byte = FCB_CMD_READ;
         FCB_OP_ERASE:    op_byte = FCB_CMD_ERASE;   // same byte twice
         FCB_OP_EVERIFY:  op_byte = FCB_CMD_EVERIFY;
         FCB_OP_PROG:     op_byte = first ? FCB_CMD_PROG : r.data;
         FCB_OP_PVERIFY:  op_byte = FCB_CMD_PVERIFY;
         FCB_OP_RESET:    op_byte = FCB_CMD_RESET;
         default:         op_byte = r.data;
      endcase
   endfunction : op_byte

   always_comb begin
      st_d   = st_q;
      req_d  = req_q;
      cnt_d  = cnt_q;
      seq_d  = seq_q;
      rd_d   = rd_q;
      pin_d  = pin_q;
      rdat_d = rdat_q;
      rval_d = 1'b0;
      idv_d  = idv_q;
      case (st_q)
         ST_IDLE: begin
            if (req_valid_in) begin
               req_d = req_in;
               seq_d = op_cycles(req_in.op);
               // erase, program, both verifies and plain writes need the high supply; refused otherwise
               if ((req_in.op == FCB_OP_ERASE || req_in.op == FCB_OP_PROG
                    || req_in.op == FCB_OP_EVERIFY || req_in.op == FCB_OP_PVERIFY
                    || req_in.op == FCB_OP_WRITE) && !supply_high_in) begin
                  st_d = ST_IDLE;
               end else begin
                  rd_d              = (req_in.op == FCB_OP_READ);
                  idv_d             = (req_in.op == FCB_OP_SIG);
                  pin_d.chip_sel_n  = 1'b0;
                  pin_d.addr        = (req_in.op == FCB_OP_SIG) ?
                                      (req_in.addr[0] ? FCB_SIG_DEV_ADDR : FCB_SIG_MFR_ADDR)
                                      : ((req_in.op == FCB_OP_PROG) ? 17'h00000
                                         : req_in.addr);
                  pin_d.dq          = op_byte(req_in, 1'b1);
                  cnt_d             = 8'(SETUP_CYC);
                  st_d              = ST_SETUP;
                  if (req_in.op == FCB_OP_READ || req_in.op == FCB_OP_SIG) begin
                     rd_d = 1'b1;
                  end
               end
            end
         end
         ST_SETUP: begin
            // address stable before the strobe so the falling edge latches it
            if (cnt_q <= 8'h01) begin
               if (rd_q) begin
                  pin_d.out_gate_n = 1'b0;
                  cnt_d            = 8'(READ_CYC);
                  st_d             = ST_READ;
               end else begin
                  pin_d.dq_oe_n = 1'b0;
                  pin_d.write_n = 1'b0;
                  cnt_d         = 8'(STROBE_CYC);
                  st_d          = ST_STROBE;
               end
            end else begin
               cnt_d = cnt_q - 8'h01;
            end
         end
         ST_STROBE: begin
            if (cnt_q <= 8'h01) begin
               pin_d.write_n = 1'b1;         // data latched on this rise
               st_d          = ST_HOLD;
            end else begin
               cnt_d = cnt_q - 8'h01;
            end
         end
         ST_HOLD: begin
            pin_d.dq_oe_n = 1'b1;
            if (seq_q > 2'd1) begin
               seq_d = seq_q - 2'd1;
               if (req_q.op == FCB_OP_PROG) begin
                  pin_d.addr = req_q.addr;   // target address on second write
               end
               pin_d.dq = op_byte(req_q, 1'b0);
               cnt_d    = 8'(SETUP_CYC);
               st_d     = ST_SETUP;
               if (req_q.op == FCB_OP_EVERIFY || req_q.op == FCB_OP_PVERIFY) begin
                  rd_d = 1'b1;               // following read
               end
            end else begin
               st_d = ST_GAP;
            end
         end
         ST_READ: begin
            if (cnt_q <= 8'h01) begin
               rdat_d           = dq_in;
               rval_d           = 1'b1;
               pin_d.out_gate_n = 1'b1;
               st_d             = ST_GAP;
            end else begin
               cnt_d = cnt_q - 8'h01;
            end
         end
         default: begin
            // deselect between requests; device finishes any operation itself
            pin_d.chip_sel_n = 1'b1;
            idv_d            = 1'b0;
            rd_d             = 1'b0;
            st_d             = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         st_q   <= ST_IDLE;
         req_q  <= '0;
         cnt_q  <= 8'h00;
         seq_q  <= 2'd0;
         rd_q   <= 1'b0;
         pin_q  <= '{chip_sel_n: 1'b1, out_gate_n: 1'b1, write_n: 1'b1,
                    addr: 17'h00000, dq: 8'h00, dq_oe_n: 1'b1};
         rdat_q <= 8'h00;
         rval_q <= 1'b0;
         idv_q  <= 1'b0;
      end else begin
         st_q   <= st_d;
         req_q  <= req_d;
         cnt_q  <= cnt_d;
         seq_q  <= seq_d;
         rd_q   <= rd_d;
         pin_q  <= pin_d;
         rdat_q <= rdat_d;
         rval_q <= rval_d;
         idv_q  <= idv_d;
      end
   end

   a_gate_needs_sel: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      !pin_q.out_gate_n |-> !pin_q.chip_sel_n) else $error("gate low without select");
   a_strobe_needs_sel: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      !pin_q.write_n |-> !pin_q.chip_sel_n) else $error("strobe without select");
   a_no_contention: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      !(pin_q.dq_oe_n == 1'b0 && pin_q.out_gate_n == 1'b0)) else $error("bus fight");
   a_strobe_width: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      $fell(pin_q.write_n) |-> !pin_q.write_n [*2] ##1 pin_q.write_n)
      else $error("strobe width wrong");
   a_data_during_strobe: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      !pin_q.write_n |-> !pin_q.dq_oe_n && $stable(pin_q.dq)) else $error("data moved");
   a_idv_read_only: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      idv_q |-> pin_q.write_n) else $error("write with id voltage");
   a_erase_gated: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      (st_q == ST_IDLE && req_valid_in && req_in.op == FCB_OP_ERASE && !supply_high_in)
      |=> st_q == ST_IDLE) else $error("erase without supply");
   a_read_result: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      $rose(pin_q.out_gate_n) |-> rval_q) else $error("read lost");
endmodule : fcb_host
`default_nettype wire

// ---- design/fcb_pkg.sv ----
package fcb_pkg;
   localparam logic [7:0] FCB_CMD_READ     = 8'h00;
   localparam logic [7:0] FCB_CMD_SIG      = 8'h90;
   localparam logic [7:0] FCB_CMD_ERASE    = 8'h20;
   localparam logic [7:0] FCB_CMD_EVERIFY  = 8'hA0;
   localparam logic [7:0] FCB_CMD_PROG     = 8'h40;
   localparam logic [7:0] FCB_CMD_PVERIFY  = 8'hC0;
   localparam logic [7:0] FCB_CMD_RESET    = 8'hFF;
   localparam int         FCB_ADDR_W       = 17;
   localparam logic [16:0] FCB_SIG_MFR_ADDR = 17'h00000;
   localparam logic [16:0] FCB_SIG_DEV_ADDR = 17'h00001;
   // bus phase lengths in cycles of the 50 ns clock
   localparam int         FCB_CLK_NS       = 50;
   localparam int         FCB_SETUP_NS     = 50;
   localparam int         FCB_STROBE_NS    = 100;
   localparam int         FCB_READ_NS      = 150;
   localparam int         FCB_SETUP_CYC    = (FCB_SETUP_NS + FCB_CLK_NS - 1) / FCB_CLK_NS;
   localparam int         FCB_STROBE_CYC   = (FCB_STROBE_NS + FCB_CLK_NS - 1) / FCB_CLK_NS;
   localparam int         FCB_READ_CYC     = (FCB_READ_NS + FCB_CLK_NS - 1) / FCB_CLK_NS;

   typedef enum logic [3:0] {
      FCB_OP_READ,
      FCB_OP_WRITE,
      FCB_OP_SIG,
      FCB_OP_ARRAY,
      FCB_OP_ERASE,
      FCB_OP_EVERIFY,
      FCB_OP_PROG,
      FCB_OP_PVERIFY,
      FCB_OP_RESET
   } fcb_op_t;

   typedef struct packed {
      fcb_op_t     op;
      logic [16:0] addr;
      logic [7:0]  data;
   } fcb_req_t;

   typedef struct packed {
      logic        chip_sel_n;
      logic        out_gate_n;
      logic        write_n;
      logic [16:0] addr;
      logic [7:0]  dq;
      logic        dq_oe_n;
   } fcb_pins_t;
endpackage : fcb_pkg

// ---- verif/fcb_flash_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module fcb_flash_model
   import fcb_pkg::*;
#(
   parameter logic [7:0] MFR_CODE = 8'hA5, // arbitrary value
   parameter logic [7:0] DEV_CODE = 8'h5C  // arbitrary value
) (
   input  wire fcb_pins_t  pins_in,
   input  wire logic       id_high_voltage_in,
   input  wire logic       supply_high_in,
   output logic [7:0]      dq_out
);
   logic [7:0]  mem_q [16];
   logic [7:0]  cmd_q = 8'h00;
   logic [16:0] fall_q;
   logic [16:0] verify_q;
   logic [16:0] target_q;
   logic [7:0]  rd_val;
   logic [7:0]  last_q = 8'h00;
   logic        drive;

   initial begin
      for (int i = 0; i < 16; i++) begin
         mem_q[i] = 8'h30 + 8'(i);
      end
   end
   always @(negedge supply_high_in) cmd_q = 8'h00;
   always @(negedge pins_in.write_n) begin
      if (!pins_in.chip_sel_n) fall_q = pins_in.addr;
   end
   // busy states 41H and 21H survive deselect until the next write or a supply drop ends them
   always @(posedge pins_in.write_n) begin
      if (!pins_in.chip_sel_n && supply_high_in) begin
         if (cmd_q == FCB_CMD_PROG) begin
            target_q = fall_q;
            mem_q[fall_q[3:0]] = mem_q[fall_q[3:0]] & pins_in.dq;
            cmd_q = 8'h41;
         end else if (cmd_q == FCB_CMD_ERASE && pins_in.dq == FCB_CMD_ERASE) begin
            foreach (mem_q[i]) mem_q[i] = 8'hFF;
            cmd_q = 8'h21;
         end else if (cmd_q == FCB_CMD_RESET && pins_in.dq == FCB_CMD_RESET) begin
            cmd_q = FCB_CMD_READ;
         end else begin
            cmd_q = pins_in.dq;
            if (pins_in.dq == FCB_CMD_EVERIFY) verify_q = fall_q;
         end
      end
   end
   always @* begin
      rd_val = mem_q[pins_in.addr[3:0]];
      if (id_high_voltage_in) begin
         rd_val = pins_in.addr[0] ? DEV_CODE : MFR_CODE;
      end else if (supply_high_in) begin
         case (cmd_q)
            FCB_CMD_SIG:     rd_val = pins_in.addr[0] ? DEV_CODE : MFR_CODE;
            FCB_CMD_EVERIFY: rd_val = mem_q[verify_q[3:0]];
            FCB_CMD_PVERIFY: rd_val = mem_q[target_q[3:0]];
            default: ;
         endcase
      end
   end
   // a floating bus shows the inverse of the last byte, never a held value
   assign drive = !pins_in.chip_sel_n && !pins_in.out_gate_n;
   always @* if (drive) last_q = rd_val;
   assign dq_out = drive ? rd_val : ~last_q;
endmodule : fcb_flash_model
`default_nettype wire

// ---- verif/flash_command_bus_interface_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module flash_command_bus_interface_bench;
   import fcb_pkg::*;
   localparam logic [7:0] MFR = 8'hA5; // arbitrary value
   localparam logic [7:0] DEV = 8'h5C; // arbitrary value
   logic clk, rst, valid, sup, ready, rvalid, busy, idhv;
   logic [7:0]  rdata, dq;
   logic [15:0] r;
   fcb_req_t    req;
   fcb_pins_t   pins;
   int fails = 0;
   int checked = 0;

   fcb_host i_dut (.ref_clk_in(clk), .sys_rst_in(rst), .req_in(req), .req_valid_in(valid),
      .req_ready_out(ready), .rd_data_out(rdata), .rd_valid_out(rvalid), .busy_out(busy),
      .pins_out(pins), .dq_in(dq), .supply_high_in(sup), .id_high_voltage_out(idhv));
   fcb_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) i_dev (.pins_in(pins),
      .id_high_voltage_in(idhv), .supply_high_in(sup), .dq_out(dq));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      if (!rst && pins.write_n === 1'b0 && (pins.chip_sel_n !== 1'b0 || pins.dq_oe_n !== 1'b0)) begin
         fails++;
         $display("ERROR write strobe expected select and drive seen %b %b", pins.chip_sel_n, pins.dq_oe_n);
      end
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic run(input fcb_op_t op, input logic [16:0] a, input logic [7:0] d);
      int n;
      r = 16'h0000;
      @(negedge clk);
      req = '{op, a, d};
      valid = 1'b1;
      n = 0;
      while (ready !== 1'b1 && n < 50) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      valid = 1'b0;
      for (n = 0; n < 50 && busy !== 1'b0; n++) begin
         if (rvalid === 1'b1) r = {r[7:0], rdata};
         @(negedge clk);
      end
      chk("idle", 16'h0000, 16'(n / 50));
   endtask : run
   task automatic t_supply_low;
      sup = 1'b0;
      run(FCB_OP_PROG, 17'h00003, 8'h00);
      run(FCB_OP_ERASE, 17'h00000, 8'h00);
      run(FCB_OP_WRITE, 17'h00000, FCB_CMD_SIG);
      run(FCB_OP_READ, 17'h00003, 8'h00);
      chk("array low", 16'h0033, r);
      run(FCB_OP_SIG, 17'h00000, 8'h00);
      chk("pin signature mfr", 16'h0000 | MFR, r);
      run(FCB_OP_SIG, 17'h00001, 8'h00);
      chk("pin signature dev", 16'h0000 | DEV, r);
   endtask : t_supply_low
   task automatic t_sig_cmd;
      sup = 1'b1;
      run(FCB_OP_WRITE, 17'h00000, FCB_CMD_SIG);
      run(FCB_OP_READ, 17'h00001, 8'h00);
      chk("sig dev", 16'h0000 | DEV, r);
      run(FCB_OP_READ, 17'h00000, 8'h00);
      chk("sig mfr", 16'h0000 | MFR, r);
      run(FCB_OP_ARRAY, 17'h00009, 8'h00);
      run(FCB_OP_READ, 17'h00001, 8'h00);
      chk("array read", 16'h0031, r);
   endtask : t_sig_cmd
   task automatic t_prog_erase;
      run(FCB_OP_PROG, 17'h00005, 8'h3C);
      run(FCB_OP_PVERIFY, 17'h00000, 8'h00);
      chk("prog verify", 16'h0034, r);
      run(FCB_OP_ERASE, 17'h00000, 8'h00);
      run(FCB_OP_EVERIFY, 17'h00005, 8'h00);
      chk("erase verify", 16'h00FF, r);
      run(FCB_OP_WRITE, 17'h00000, FCB_CMD_SIG);
      run(FCB_OP_RESET, 17'h00000, 8'h00);
      run(FCB_OP_ARRAY, 17'h00000, 8'h00);
      run(FCB_OP_READ, 17'h00000, 8'h00);
      chk("after reset", 16'h00FF, r);
      run(FCB_OP_WRITE, 17'h00000, FCB_CMD_SIG);
      @(negedge clk);
      sup = 1'b0;
      @(negedge clk);
      sup = 1'b1;
      run(FCB_OP_READ, 17'h00000, 8'h00);
      chk("supply drop", 16'h00FF, r);
   endtask : t_prog_erase
   task automatic tally_and_finish;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      #100000;
      fails++;
      tally_and_finish();
   end
   initial begin
      rst = 1'b1;
      valid = 1'b0;
      sup = 1'b0;
      req = '0;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      t_supply_low();
      t_sig_cmd();
      t_prog_erase();
      tally_and_finish();
   end
endmodule : flash_command_bus_interface_bench
`default_nettype wire
